// ===== include/sadc_pkg.sv
package sadc_pkg;
    // code width and tap count
    localparam int CODE_W = 4;
    localparam int TAP_N = 16;
    // tap scale: level of code n is (2n+1)/34 of reference, code 0 is ground
    localparam int LEVEL_DEN = 34;
    // level numerators at the comparator, in 1/34 units of reference
    localparam logic [5:0] LEVEL_NUM_ZERO = 6'h00;
    localparam logic [CODE_W-1:0] CODE_RESET = 4'h0;
    localparam logic [CODE_W-1:0] CODE_TOP = 4'hF;
    // analog input resolution, sample handed in as a fraction vin/2^VIN_W of reference
    localparam int VIN_W = 12;

    // instruction kinds the core presents to the converter port
    typedef enum logic [2:0] {
        SADC_OP_NONE = 3'b000,
        SADC_OP_OUT = 3'b001,
        SADC_OP_SET_BIT = 3'b010,
        SADC_OP_CLR_BIT = 3'b011,
        SADC_OP_IN = 3'b100,
        SADC_OP_TEST_BIT_T = 3'b101,
        SADC_OP_TEST_BIT_F = 3'b110,
        SADC_OP_TEST_CMP = 3'b111
    } sadc_op_e;

    // one port request from the core
    typedef struct packed {
        sadc_op_e op;
        logic cmp_skip_true;
        logic [CODE_W-1:0] data;
    } sadc_req_s;

    // answer back to the core
    typedef struct packed {
        logic valid;
        logic skip;
        logic [CODE_W-1:0] data;
    } sadc_rsp_s;
endpackage : sadc_pkg

// ===== rtl/sadc_ladder.sv
`timescale 1ns/1ps
// tap ladder plus comparator model, purely combinational
module sadc_ladder
    import sadc_pkg::*;
(
    input wire logic [CODE_W-1:0] code_i,
    input wire logic [VIN_W-1:0] vin_i,
    output logic above_o
);
    logic [VIN_W+5:0] vin_scaled;
    logic [VIN_W+5:0] tap_scaled;
    logic [5:0] level_num;

    // tap numerator: ground for code zero, else 2n+1
    always_comb begin
        if (code_i == CODE_RESET) begin
            level_num = LEVEL_NUM_ZERO;
        end else begin
            level_num = {1'b0, code_i, 1'b1};
        end
    end

    // compare vin/2^VIN_W against level/34 without division
    always_comb begin
        vin_scaled = (VIN_W + 6)'(vin_i) * (VIN_W + 6)'(LEVEL_DEN);
        tap_scaled = (VIN_W + 6)'(level_num) << VIN_W;
    end

    // strict greater: equal input reads as false
    assign above_o = vin_scaled > tap_scaled;
endmodule : sadc_ladder

// ===== rtl/sadc_ctrl.sv
`timescale 1ns/1ps
// Function
// - four-bit converter port, loaded and read back
// - code selects one of sixteen ladder taps
// - true only when input exceeds tap
// - skip on true or on false tests
// - code zero ground, else (2n+1)/34
// - result n: tap n below, n+1 not
// - input pin doubles as programmable-threshold bit
module sadc_ctrl
    import sadc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire sadc_req_s req_i,
    input wire logic [VIN_W-1:0] vin_i,
    output sadc_rsp_s rsp_o,
    output logic [CODE_W-1:0] code_o,
    output logic cmp_o
);

    // limitations: one request per cycle, no queueing; a compare test
    // taken in the cycle right after a port write still sees the old tap,
    // so software must leave one idle cycle between a write and a test.
    // the search itself lives in software; this block only holds the code,
    // picks the tap and answers reads and tests.

    // port latch, registered comparator and the answer register
    logic [CODE_W-1:0] code;
    logic cmp;
    logic cmp_raw;
    sadc_rsp_s rsp;
    logic [CODE_W-1:0] next_code;

    // decoded request kinds, one flag each
    logic is_out;
    logic is_set;
    logic is_clr;
    logic is_in;
    logic is_tbit_t;
    logic is_tbit_f;
    logic is_tcmp;
    logic is_answer;

    // per-bit view of the port under the request mask
    logic [CODE_W-1:0] masked_bits;
    logic any_masked_one;
    logic all_masked_zero;

    // skip decisions for the answer register
    logic cmp_skip;
    logic bit_skip;
    logic next_skip;

    // ladder and comparator, threshold set by the port code
    sadc_ladder u_ladder (
        .code_i(code),
        .vin_i(vin_i),
        .above_o(cmp_raw)
    );

    // request decode; only one kind is active per cycle, none sets nothing
    always_comb begin
        is_out = 1'b0;
        is_set = 1'b0;
        is_clr = 1'b0;
        is_in = 1'b0;
        is_tbit_t = 1'b0;
        is_tbit_f = 1'b0;
        is_tcmp = 1'b0;
        case (req_i.op)
            SADC_OP_OUT: begin
                is_out = 1'b1;
            end
            SADC_OP_SET_BIT: begin
                is_set = 1'b1;
            end
            SADC_OP_CLR_BIT: begin
                is_clr = 1'b1;
            end
            SADC_OP_IN: begin
                is_in = 1'b1;
            end
            SADC_OP_TEST_BIT_T: begin
                is_tbit_t = 1'b1;
            end
            SADC_OP_TEST_BIT_F: begin
                is_tbit_f = 1'b1;
            end
            SADC_OP_TEST_CMP: begin
                is_tcmp = 1'b1;
            end
            default: begin
                is_out = 1'b0;
            end
        endcase
    end

    // every read or test gets exactly one answer
    assign is_answer = is_in | is_tbit_t | is_tbit_f | is_tcmp;

    // port write path, one slice per bit; set and clear touch only the
    // masked bits, so a partial update never disturbs the settled bits
    for (genvar i = 0; i < CODE_W; i++) begin : g_port_bit
        always_comb begin
            if (is_out) begin
                next_code[i] = req_i.data[i];
            end else if (is_set && req_i.data[i]) begin
                next_code[i] = 1'b1;
            end else if (is_clr && req_i.data[i]) begin
                next_code[i] = 1'b0;
            end else begin
                next_code[i] = code[i];
            end
        end

        // masked view for the bit tests
        assign masked_bits[i] = code[i] & req_i.data[i];
    end

    // bit test outcomes: any masked one, or all masked zero
    assign any_masked_one = |masked_bits;
    assign all_masked_zero = ~any_masked_one;

    // skip decision; a compare test uses the sampled result, which
    // belongs to the code held one cycle earlier
    always_comb begin
        bit_skip = 1'b0;
        cmp_skip = req_i.cmp_skip_true ? cmp : ~cmp;
        if (is_tbit_t) begin
            bit_skip = any_masked_one;
        end else if (is_tbit_f) begin
            bit_skip = all_masked_zero;
        end
        if (is_tcmp) begin
            next_skip = cmp_skip;
        end else begin
            next_skip = bit_skip;
        end
    end

    // converter port latch
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            code <= CODE_RESET;
        end else begin
            code <= next_code;
        end
    end

    // analog comparison is asynchronous to the core, so it is sampled once
    // here; the extra cycle of latency is the price of a clean test
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cmp <= 1'b0;
        end else begin
            cmp <= cmp_raw;
        end
    end

    // answer strobe, one cycle after a read or test
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rsp.valid <= 1'b0;
        end else begin
            rsp.valid <= is_answer;
        end
    end

    // skip flag, low outside tests so a stale skip is never seen
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rsp.skip <= 1'b0;
        end else begin
            rsp.skip <= next_skip;
        end
    end

    // read-back data always carries the held code
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rsp.data <= CODE_RESET;
        end else begin
            rsp.data <= code;
        end
    end

    // outputs straight from flip-flops
    assign rsp_o = rsp;
    assign code_o = code;
    assign cmp_o = cmp;

endmodule : sadc_ctrl

// ===== verif/sadc_ctrl_checker.sv
`timescale 1ns/1ps
module sadc_ctrl_checker import sadc_pkg::*; (
    input logic core_clk_i,
    input logic reset_n_i,
    input sadc_req_s req_i,
    input logic [VIN_W-1:0] vin_i,
    input sadc_rsp_s rsp_o,
    input logic [CODE_W-1:0] code_o,
    input logic cmp_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    // tap numerator, ground at code zero
    wire [4:0] lvl = (code_o == 4'h0) ? 5'h00 : {code_o, 1'b1};
    wire sadc_op_e op = req_i.op;
    wire [3:0] d = req_i.data;
    sequence tst_s; op == SADC_OP_TEST_CMP; endsequence
    load_port_a: assert property (op == SADC_OP_OUT |=> code_o == $past(d)) else $error("load");
    set_bit_a: assert property (op == SADC_OP_SET_BIT |=> code_o == $past(code_o | d))
        else $error("set");
    clr_bit_a: assert property (op == SADC_OP_CLR_BIT |=> code_o == $past(code_o & ~d))
        else $error("clear");
    read_back_a: assert property (op == SADC_OP_IN |=> rsp_o.data == $past(code_o))
        else $error("read");
    tap_compare_a: assert property (cmp_o == (34 * $past(vin_i) > 4096 * $past(lvl)))
        else $error("compare");
    skip_cmp_a: assert property (tst_s |=> rsp_o.skip == ($past(req_i.cmp_skip_true) ~^ $past(cmp_o)))
        else $error("skip");
    bit_test_a: assert property (op == SADC_OP_TEST_BIT_T |=> rsp_o.skip == $past(|(code_o & d)))
        else $error("bit test");
    answer_a: assert property (op[2] |=> rsp_o.valid) else $error("answer");
    no_answer_a: assert property (!op[2] |=> !rsp_o.valid) else $error("stray");
endmodule : sadc_ctrl_checker

// ===== verif/sadc_core.sv
`timescale 1ns/1ps
// core side: one request a cycle, answer read one cycle later
module sadc_core import sadc_pkg::*; (
    input wire logic clk_i,
    input wire sadc_rsp_s rsp_i,
    output sadc_req_s req_o
);
    initial req_o = '0;
    task automatic put(input sadc_op_e op, input logic [3:0] d, input logic st = 1'b1);
        req_o = '{op, st, d};
        @(negedge clk_i);
    endtask : put
    // idle cycle lets answer and comparator settle
    task automatic nap;
        req_o = '0;
        @(negedge clk_i);
    endtask : nap
    // search from 1000B, skip-on-true test only on the bit 1 step, skip-on-false on the others
    task automatic convert(output logic [3:0] res);
        logic [3:0] b;
        logic s;
        b = 4'h8;
        put(SADC_OP_OUT, b);
        repeat (4) begin
            nap;
            put(SADC_OP_TEST_CMP, 4'h0, b[1]);
            // answer stands for this one cycle only
            s = rsp_i.skip;
            nap;
            if (s !== b[1]) put(SADC_OP_CLR_BIT, b);
            b = b >> 1;
            if (b != 4'h0) put(SADC_OP_SET_BIT, b);
        end
        put(SADC_OP_IN, 4'h0);
        res = rsp_i.data;
        nap;
    endtask : convert
endmodule : sadc_core

// ===== verif/sadc_ctrl_tb.sv
`timescale 1ns/1ps
`define CK(n, e, s) begin checked++; if ((s) !== (e)) begin n_fail++; \
    $display("unexpected %s exp %h got %h", n, e, s); end end
module sadc_ctrl_tb import sadc_pkg::*; ();
    logic core_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [VIN_W-1:0] vin_i = '0;
    sadc_req_s req_i;
    sadc_rsp_s rsp_o;
    logic [CODE_W-1:0] code_o;
    logic cmp_o;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    sadc_ctrl uut (.core_clk_i, .reset_n_i, .req_i, .vin_i, .rsp_o, .code_o, .cmp_o);
    sadc_core core (.clk_i(core_clk_i), .rsp_i(rsp_o), .req_o(req_i));
    initial forever #4 core_clk_i = ~core_clk_i;
    // hang guard, a full run needs under 150 cycles
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            report_and_stop;
        end
    end
    task automatic report_and_stop;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    // one search per input, pin view checked against final code
    task automatic t_conv(input int v);
        logic [3:0] got;
        logic [3:0] exp;
        vin_i = v[VIN_W-1:0];
        exp = 4'h0;
        for (int n = 1; n < 16; n++) if (v * 34 > (2 * n + 1) * 4096) exp = n[3:0];
        core.convert(got);
        `CK("result", exp, got)
        `CK("pin", v != 0, cmp_o)
    endtask : t_conv
    // bit tests, masked set/clear and answer strobe on a fixed pattern
    task automatic t_bits;
        core.put(SADC_OP_OUT, 4'hA);
        `CK("code", 4'hA, code_o)
        core.put(SADC_OP_TEST_BIT_T, 4'h2);
        `CK("valid", 1'b1, rsp_o.valid)
        `CK("bit_t skip", 1'b1, rsp_o.skip)
        core.put(SADC_OP_TEST_BIT_F, 4'h5);
        `CK("bit_f skip", 1'b1, rsp_o.skip)
        core.put(SADC_OP_TEST_BIT_T, 4'h5);
        `CK("bit_t noskip", 1'b0, rsp_o.skip)
        core.put(SADC_OP_TEST_BIT_F, 4'h8);
        `CK("bit_f noskip", 1'b0, rsp_o.skip)
        `CK("read data", 4'hA, rsp_o.data)
        core.put(SADC_OP_SET_BIT, 4'h5);
        core.put(SADC_OP_CLR_BIT, 4'h3);
        `CK("masked code", 4'hC, code_o)
        `CK("no answer", 1'b0, rsp_o.valid)
        core.nap;
    endtask : t_bits
    // tap edges: 361/362 straddle code 1, 3734/3735 the top tap
    initial begin
        repeat (2) @(negedge core_clk_i);
        reset_n_i = 1'b1;
        t_bits;
        t_conv(0);
        t_conv(361);
        t_conv(362);
        t_conv(2048);
        t_conv(3734);
        t_conv(3735);
        report_and_stop;
    end
endmodule : sadc_ctrl_tb
bind sadc_ctrl sadc_ctrl_checker chk (.core_clk_i, .reset_n_i, .req_i, .vin_i, .rsp_o,
    .code_o, .cmp_o);
